// ===== rtl/bzd_pkg.sv
package bzd_pkg;
	// Core clock and fast sampling rate
	localparam int CLK_HZ = 100_000_000;
	localparam int FAST_HZ = 800_000;
	localparam int FAST_DIV = CLK_HZ / FAST_HZ;
	// Control register A fields
	localparam int CRA_DRIVE_BIT = 3;
	localparam int CRA_SENSOR_BIT = 5;
	// Control register B fields
	localparam int CRB_THR_HI = 7;
	localparam int CRB_THR_LO = 6;
	localparam int CRB_POL_BIT = 5;
	localparam int CRB_SDM_BIT = 4;
	localparam int CRB_HDM_BIT = 3;
	// Parity register fields
	localparam int PAR_EDGE_BIT = 7;
	localparam int PAR_CHAN_BIT = 6;
	// Phase state register fields
	localparam int PHS_SEL_HI = 7;
	localparam int PHS_SEL_LO = 6;
	// Phase select codes
	localparam logic [1:0] SEL_A = 2'h0;
	localparam logic [1:0] SEL_B = 2'h1;
	localparam logic [1:0] SEL_C = 2'h2;
	// Reset values
	localparam logic [7:0] CRB_RST = 8'h00;
	localparam logic [7:0] PHS_RST = 8'h00;
	localparam logic [7:0] DEMAG_RST = 8'hFF;
	localparam logic [7:0] TMR_RST = 8'h00;
	// Correction coefficient is a fraction of 32
	localparam int CORR_SHIFT = 5;
	// Position within a motor step
	typedef enum logic [1:0] {ST_DELAY, ST_DEMAG, ST_ZWIN} bzd_step_t;
endpackage

// ===== rtl/bzd_smp_if.sv
`timescale 1ns/1ps
// Carries mode and clock sources to the sampler and strobes back
interface bzd_smp_if;
	logic sensorMode;
	logic voltMode;
	logic intPwm;
	logic extPwm;
	logic fastTick;
	logic zStrobe;
	modport ctl(output sensorMode, output voltMode, output intPwm, output extPwm,
		input fastTick, input zStrobe);
	modport gen(input sensorMode, input voltMode, input intPwm, input extPwm,
		output fastTick, output zStrobe);
endinterface

// ===== rtl/bzd_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin inputs
module bzd_sync #(
	parameter int W = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1; // First stage, read only by second
		logic [W-1:0] s2; // Stable output stage
	} bzd_sync_t;
	bzd_sync_t s;
	bzd_sync_t n;

	// Shift pins through two stages
	always_comb begin
		n.s1 = din;
		n.s2 = s.s1;
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dout = s.s2;
endmodule

// ===== rtl/bzd_sampler.sv
`timescale 1ns/1ps
// Builds the fast tick and the mode-dependent zero-crossing strobe
module bzd_sampler (
	input wire logic ref_clk,
	input wire logic rst_n,
	bzd_smp_if.gen g
);
	localparam int DW = $clog2(bzd_pkg::FAST_DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(bzd_pkg::FAST_DIV - 1);
	typedef struct packed {
		logic [DW-1:0] div; // Fast rate divider
		logic intLast; // Internal PWM previous level
		logic extLast; // Timer PWM previous level
		logic fast; // Fast tick pulse
		logic zs; // Zero-crossing strobe pulse
	} bzd_smp_t;
	bzd_smp_t s;
	bzd_smp_t n;

	// Divider and edge detection of the sampling sources
	always_comb begin
		n = s;
		n.intLast = g.intPwm;
		n.extLast = g.extPwm;
		n.fast = 1'b0;
		n.div = s.div + 1'b1;
		if (s.div == DIV_LAST) begin
			n.div = '0;
			n.fast = 1'b1;
		end
		if (g.sensorMode) begin
			n.zs = n.fast;
		end else if (g.voltMode) begin
			n.zs = g.extPwm && !s.extLast;
		end else begin
			n.zs = g.intPwm && !s.intLast;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign g.fastTick = s.fast;
	assign g.zStrobe = s.zs;

	// The strobe follows the mode seen one cycle earlier
	property p_sensor_rate;
		@(posedge ref_clk) disable iff (!rst_n)
		$past(g.sensorMode) |-> s.zs == s.fast;
	endproperty
	a_sensor_rate: assert property (p_sensor_rate)
		else $error("sensor strobe not on fast tick");
endmodule

// ===== rtl/bzd_detector.sv
`timescale 1ns/1ps
// What this block does
// - Commutation, then demagnetisation, then zero crossing
// - Demag sampling always at fast fixed rate
// - Delay runs from zero crossing to commutation
// - Phase state writes shadowed, applied at commutation
// - Select bits pick phase A, B or C
// - Threshold bits set one shared comparator reference
// - Four levels, same for both event kinds
// - Current mode samples on internal PWM clock
// - Voltage mode samples on external timer PWM
// - Sensor mode samples zero crossing at fast rate
// - Drive bit selects voltage or current mode
// - Parity bit picks even or odd channels
// - Edge bit picks opposite or same edges
// - Polarity bit picks rising or falling crossing
// - Sensor bit selects sensor or sensorless operation
// - Two bits choose hardware or software demag
// - Demag and polarity bits buffered to commutation
// - Hardware demag captures step timer value
// - Capture scaled by coefficient, written back
// - Timer past emulated value gives no event
// - Zero crossing captures timer, resets if auto
// - Commutation when timer reaches compare value
module bzd_detector (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic phaseAInput,
	input wire logic phaseBInput,
	input wire logic phaseCInput,
	input wire logic timerPwm,
	input wire logic intPwmClk,
	input wire logic stepTick,
	input wire logic autoCommutate,
	input wire logic [7:0] controlRegA,
	input wire logic controlRegBWr,
	input wire logic [7:0] controlRegBData,
	input wire logic phaseStateWr,
	input wire logic [7:0] phaseStateData,
	input wire logic [7:0] parityReg,
	input wire logic [7:0] commutationCompare,
	input wire logic [7:0] corrCoef,
	input wire logic demagTimeWr,
	input wire logic [7:0] demagTimeData,
	output logic [1:0] thresholdSelect,
	output logic channelParitySel,
	output logic [1:0] inputPhaseSelect,
	output logic [7:0] stepTimer,
	output logic [7:0] zCapture,
	output logic [7:0] demagTimeReg,
	output logic commEvent,
	output logic demagEvent,
	output logic zcEvent,
	output logic [1:0] stepPhase
);
	typedef struct packed {
		bzd_pkg::bzd_step_t step; // Position in the step
		logic [7:0] tmr; // Step timer
		logic [7:0] zCap; // Timer at last zero crossing
		logic [7:0] dTime; // Demag time register
		logic [7:0] crb; // Control register B as written
		logic [7:0] phs; // Phase state shadow copy
		logic [1:0] actSel; // Active phase select
		logic actPol; // Active crossing polarity
		logic actHw; // Active hardware demag enable
		logic actSw; // Active software demag enable
		logic noWin; // Emulated value already passed
		logic zSmp; // Last zero-crossing sample
		logic dSmp; // Last demag sample
		logic zSeen; // Zero-crossing sample valid
		logic dSeen; // Demag sample valid
		logic cEv; // Commutation pulse
		logic dEv; // Demag pulse
		logic zEv; // Zero-crossing pulse
		logic scalePend; // Capture awaits scaling
		logic odd; // Odd channel group selected
	} bzd_det_t;
	bzd_det_t s;
	bzd_det_t n;

	logic [3:0] pinSync; // Synchronised comparator and timer pins
	logic cmpBit; // Comparator of the monitored phase
	logic dRiseSel; // Demag edge is rising
	logic zEdge; // Qualified zero-crossing edge
	logic dEdge; // Qualified demag edge
	logic [15:0] prod; // Capture times coefficient
	logic [15:0] shifted; // Product divided by 32
	logic [7:0] scaled; // Saturated emulated demag time

	bzd_smp_if smp();

	// Pins from the motor and the other timer cross in here
	bzd_sync #(
		.W(4)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.din({timerPwm, phaseCInput, phaseBInput, phaseAInput}),
		.dout(pinSync)
	);

	// Mode selection for the sampler
	assign smp.sensorMode = controlRegA[bzd_pkg::CRA_SENSOR_BIT];
	assign smp.voltMode = controlRegA[bzd_pkg::CRA_DRIVE_BIT];
	assign smp.intPwm = intPwmClk;
	assign smp.extPwm = pinSync[3];

	bzd_sampler u_smp (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.g(smp.gen)
	);

	// Route the monitored phase to the detector
	always_comb begin
		case (s.actSel)
			bzd_pkg::SEL_A: cmpBit = pinSync[0];
			bzd_pkg::SEL_B: cmpBit = pinSync[1];
			bzd_pkg::SEL_C: cmpBit = pinSync[2];
			default: cmpBit = pinSync[0];
		endcase
	end

	// Edge qualification
	always_comb begin
		// Opposite edge when the relation bit is clear
		dRiseSel = parityReg[bzd_pkg::PAR_EDGE_BIT] ? s.actPol : !s.actPol;
		// Polarity set means rising crossing
		zEdge = smp.zStrobe && s.zSeen &&
			(s.actPol ? (!s.zSmp && cmpBit) : (s.zSmp && !cmpBit));
		dEdge = smp.fastTick && s.dSeen &&
			(dRiseSel ? (!s.dSmp && cmpBit) : (s.dSmp && !cmpBit));
	end

	// Scale the captured demag time, saturating at full scale
	always_comb begin
		prod = 16'(s.dTime) * 16'(corrCoef);
		shifted = prod >> bzd_pkg::CORR_SHIFT;
		scaled = (|shifted[15:8]) ? 8'hFF : shifted[7:0];
	end

	// Next-state logic
	always_comb begin
		n = s;
		n.cEv = 1'b0;
		n.dEv = 1'b0;
		n.zEv = 1'b0;
		n.scalePend = 1'b0;
		n.odd = parityReg[bzd_pkg::PAR_CHAN_BIT];
		// Register writes
		if (controlRegBWr) begin
			n.crb = controlRegBData;
		end
		if (phaseStateWr) begin
			n.phs = phaseStateData;
		end
		if (demagTimeWr) begin
			n.dTime = demagTimeData;
		end
		// Step timer advances on its prescaled tick
		if (stepTick) begin
			n.tmr = s.tmr + 1'b1;
		end
		// Comparator sampling on both strobes
		if (smp.fastTick) begin
			n.dSmp = cmpBit;
			n.dSeen = 1'b1;
		end
		if (smp.zStrobe) begin
			n.zSmp = cmpBit;
			n.zSeen = 1'b1;
		end
		case (s.step)
			// Waiting out the delay after the crossing
			bzd_pkg::ST_DELAY: begin
				if (s.tmr == commutationCompare) begin
					n.cEv = 1'b1;
					n.step = bzd_pkg::ST_DEMAG;
					// Preloaded settings become active
					n.actSel = s.phs[bzd_pkg::PHS_SEL_HI:bzd_pkg::PHS_SEL_LO];
					n.actPol = s.crb[bzd_pkg::CRB_POL_BIT];
					n.actSw = s.crb[bzd_pkg::CRB_SDM_BIT];
					n.actHw = s.crb[bzd_pkg::CRB_HDM_BIT];
					// Timer already past emulated value
					n.noWin = s.crb[bzd_pkg::CRB_SDM_BIT] && (s.tmr > s.dTime);
					// New phase: no edge against an old sample
					n.dSeen = 1'b0;
					n.zSeen = 1'b0;
				end
			end
			// Waiting for end of demagnetisation
			bzd_pkg::ST_DEMAG: begin
				if (s.actSw) begin
					// Emulated event when timer meets the value
					if (!s.noWin && s.tmr == s.dTime) begin
						n.dEv = 1'b1;
						n.step = bzd_pkg::ST_ZWIN;
					end
				end else if (dEdge) begin
					n.dEv = 1'b1;
					n.step = bzd_pkg::ST_ZWIN;
					if (s.actHw) begin
						n.dTime = s.tmr;
						n.scalePend = 1'b1;
					end
				end
			end
			// Zero-crossing window open
			bzd_pkg::ST_ZWIN: begin
				if (zEdge) begin
					n.zEv = 1'b1;
					n.zCap = s.tmr;
					n.step = bzd_pkg::ST_DELAY;
					if (autoCommutate) begin
						n.tmr = bzd_pkg::TMR_RST;
					end
				end
			end
			// Unused encoding
			default: begin
				n.step = bzd_pkg::ST_DELAY;
			end
		endcase
		// Write back the corrected time for the next step
		if (s.scalePend) begin
			n.dTime = scaled;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.step <= bzd_pkg::ST_DELAY;
			s.tmr <= bzd_pkg::TMR_RST;
			s.dTime <= bzd_pkg::DEMAG_RST;
			s.crb <= bzd_pkg::CRB_RST;
			s.phs <= bzd_pkg::PHS_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from state
	assign thresholdSelect = s.crb[bzd_pkg::CRB_THR_HI:bzd_pkg::CRB_THR_LO];
	assign channelParitySel = s.odd;
	assign inputPhaseSelect = s.actSel;
	assign stepTimer = s.tmr;
	assign zCapture = s.zCap;
	assign demagTimeReg = s.dTime;
	assign commEvent = s.cEv;
	assign demagEvent = s.dEv;
	assign zcEvent = s.zEv;
	assign stepPhase = s.step;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Commutation always opens the demag wait
	property p_c_then_d;
		s.cEv |-> s.step == bzd_pkg::ST_DEMAG;
	endproperty
	a_c_then_d: assert property (p_c_then_d)
		else $error("commutation not followed by demag wait");

	// Demag only from its own wait
	property p_d_order;
		s.dEv |-> $past(s.step) == bzd_pkg::ST_DEMAG && s.step == bzd_pkg::ST_ZWIN;
	endproperty
	a_d_order: assert property (p_d_order)
		else $error("demag event out of order");

	// Crossing only inside its window
	property p_z_order;
		s.zEv |-> $past(s.step) == bzd_pkg::ST_ZWIN && s.step == bzd_pkg::ST_DELAY;
	endproperty
	a_z_order: assert property (p_z_order)
		else $error("zero crossing out of order");

	// Fast tick period is exact
	property p_fast_rate;
		smp.fastTick |-> ##125 smp.fastTick;
	endproperty
	a_fast_rate: assert property (p_fast_rate)
		else $error("fast sampling period wrong");

	// Commutation one cycle after compare match
	property p_comm_match;
		s.step == bzd_pkg::ST_DELAY && s.tmr == commutationCompare |=> s.cEv;
	endproperty
	a_comm_match: assert property (p_comm_match)
		else $error("commutation missed at compare");

	// Active select comes from the shadow at commutation only
	property p_shadow;
		s.cEv |-> s.actSel == $past(s.phs[bzd_pkg::PHS_SEL_HI:bzd_pkg::PHS_SEL_LO]);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("select not taken from shadow");

	property p_sel_hold;
		!s.cEv |-> $stable(s.actSel) && $stable(s.actPol);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("active settings changed between commutations");

	// Crossing captures timer and resets it when auto
	property p_z_capture;
		s.zEv |-> s.zCap == $past(s.tmr) && (!$past(autoCommutate) || s.tmr == 8'h00);
	endproperty
	a_z_capture: assert property (p_z_capture)
		else $error("zero crossing capture wrong");

	// Emulated demag at the programmed value
	property p_sw_demag;
		s.step == bzd_pkg::ST_DEMAG && s.actSw && !s.noWin && s.tmr == s.dTime
			|=> s.dEv;
	endproperty
	a_sw_demag: assert property (p_sw_demag)
		else $error("emulated demag missed");

	// Passed value blocks the event and the window
	property p_no_window;
		s.step == bzd_pkg::ST_DEMAG && s.actSw && s.noWin |=> !s.dEv;
	endproperty
	a_no_window: assert property (p_no_window)
		else $error("demag raised after value passed");

	// Hardware capture is scaled on the next cycle
	property p_scale;
		s.scalePend |=> s.dTime == $past(scaled);
	endproperty
	a_scale: assert property (p_scale)
		else $error("demag time not scaled");

	property p_hw_capture;
		s.dEv && s.actHw && !s.actSw |-> s.scalePend && s.dTime == $past(s.tmr);
	endproperty
	a_hw_capture: assert property (p_hw_capture)
		else $error("hardware demag time not captured");
endmodule

// ===== dv/bzd_phase_model.sv
`timescale 1ns/1ps
// Motor phase comparators and the two PWM sources seen by the detector
module bzd_phase_model #(
	parameter int D_DLY = 300,
	parameter int Z_DLY = 700
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic commEvent,
	input wire logic [1:0] selPhase,
	input wire logic zcRising,
	input wire logic [1:0] pwmRun,
	output logic phaseAInput,
	output logic phaseBInput,
	output logic phaseCInput,
	output logic intPwmClk,
	output logic timerPwm
);
	int cnt; // Cycles since the last commutation
	logic [7:0] pwmCnt; // Shared count for both PWM sources
	logic [1:0] selReg; // Unenergised phase of this step
	logic polReg; // Crossing level of this step
	logic lvl; // Level of the unenergised phase
	logic noise; // Energised phases never settle
	// Pattern restarts at commutation, parked level while idle
	always_ff @(negedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5000;
			pwmCnt <= 8'h00;
			selReg <= bzd_pkg::SEL_A;
			polReg <= 1'b1;
			noise <= 1'b0;
		end else begin
			noise <= ~noise;
			pwmCnt <= pwmCnt + 8'h01;
			if (commEvent) begin
				cnt <= 0;
				selReg <= selPhase;
				polReg <= zcRising;
			end else if (cnt < 5000) begin
				cnt <= cnt + 1;
			end
		end
	end
	// Demag edge opposes the crossing edge, then a second crossing follows
	always_comb begin
		lvl = (cnt < D_DLY || (cnt >= Z_DLY && cnt < Z_DLY + 400) || cnt >= Z_DLY + 800) ?
			polReg : !polReg;
	end
	assign phaseAInput = (selReg == bzd_pkg::SEL_A || selReg == 2'h3) ? lvl : noise;
	assign phaseBInput = (selReg == bzd_pkg::SEL_B) ? lvl : noise;
	assign phaseCInput = (selReg == bzd_pkg::SEL_C) ? lvl : noise;
	// Sources stand low while stopped
	assign intPwmClk = pwmRun[0] & pwmCnt[6];
	assign timerPwm = pwmRun[1] & pwmCnt[7];
endmodule

// ===== dv/bemf_zero_cross_demag_detector_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the zero-crossing and demagnetisation detector
module bemf_zero_cross_demag_detector_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic stepTick = 1'b0;
	logic [7:0] controlRegA = 8'h00;
	logic controlRegBWr = 1'b0;
	logic [7:0] controlRegBData = 8'h00;
	logic phaseStateWr = 1'b0;
	logic [7:0] phaseStateData = 8'h00;
	logic [7:0] parityReg = 8'h00;
	logic [7:0] corrCoef = 8'h10;
	logic demagTimeWr = 1'b0;
	logic [7:0] demagTimeData = 8'h00;
	logic [1:0] selPhase = 2'h0; // Phase the model leaves unenergised
	logic zcRising = 1'b1; // Crossing edge the model makes
	logic [1:0] pwmRun = 2'h1; // Which PWM sources run
	logic phaseAInput, phaseBInput, phaseCInput, timerPwm, intPwmClk;
	logic [1:0] thresholdSelect, inputPhaseSelect, stepPhase;
	logic channelParitySel, commEvent, demagEvent, zcEvent;
	logic [7:0] stepTimer, zCapture, demagTimeReg;
	int failures = 0;
	int compares = 0;
	int cycles = 0; // Run length guard
	int waited; // Cycles spent in the last wait
	bit otherEv; // Another event pulsed during the last wait
	logic [7:0] lastT; // Timer one cycle before the last edge
	logic [1:0] curSel = 2'h0; // Active select expected
	bzd_detector bzd_detector_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.phaseAInput(phaseAInput), .phaseBInput(phaseBInput), .phaseCInput(phaseCInput),
		.timerPwm(timerPwm), .intPwmClk(intPwmClk), .stepTick(stepTick),
		.autoCommutate(1'b1), .controlRegA(controlRegA), .controlRegBWr(controlRegBWr),
		.controlRegBData(controlRegBData), .phaseStateWr(phaseStateWr),
		.phaseStateData(phaseStateData), .parityReg(parityReg),
		.commutationCompare(8'h10), .corrCoef(corrCoef), .demagTimeWr(demagTimeWr),
		.demagTimeData(demagTimeData), .thresholdSelect(thresholdSelect),
		.channelParitySel(channelParitySel), .inputPhaseSelect(inputPhaseSelect),
		.stepTimer(stepTimer), .zCapture(zCapture), .demagTimeReg(demagTimeReg),
		.commEvent(commEvent), .demagEvent(demagEvent), .zcEvent(zcEvent),
		.stepPhase(stepPhase));
	bzd_phase_model bzd_phase_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.commEvent(commEvent), .selPhase(selPhase), .zcRising(zcRising), .pwmRun(pwmRun),
		.phaseAInput(phaseAInput), .phaseBInput(phaseBInput), .phaseCInput(phaseCInput),
		.intPwmClk(intPwmClk), .timerPwm(timerPwm));
	// 100 MHz clock
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Step timer advances once every 16 cycles
	always @(negedge ref_clk) begin
		stepTick <= (cycles % 16 == 0);
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			$display("ERROR %0t run too long", $time);
			wrap_up();
		end
	end
	// Count a comparison and report a mismatch
	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			failures++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	// Expected scaled demag time, saturated
	function automatic logic [7:0] sc(input logic [7:0] t, input logic [7:0] c);
		logic [15:0] p;
		p = (16'(t) * 16'(c)) >> 5;
		return (p > 16'h00FF) ? 8'hFF : p[7:0];
	endfunction
	// One-cycle write: 0 control B, 1 phase state, 2 demag time
	task automatic wr(input int k, input logic [7:0] d);
		@(negedge ref_clk);
		controlRegBData = d;
		phaseStateData = d;
		demagTimeData = d;
		controlRegBWr = (k == 0);
		phaseStateWr = (k == 1);
		demagTimeWr = (k == 2);
		@(negedge ref_clk);
		{controlRegBWr, phaseStateWr, demagTimeWr} = 3'b000;
	endtask
	// Bounded wait for event k: 0 commutation, 1 demag, 2 crossing
	task automatic wait_ev(input int k, input int lim, output bit got);
		logic [2:0] ev;
		got = 1'b0;
		otherEv = 1'b0;
		waited = 0;
		while (!got && waited < lim) begin
			lastT = stepTimer;
			@(posedge ref_clk);
			#1;
			waited++;
			ev = {zcEvent, demagEvent, commEvent};
			if (ev[k] === 1'b1) got = 1'b1;
			if ((ev & ~(3'b001 << k)) !== 3'b000) otherEv = 1'b1;
		end
	endtask
	task automatic do_reset();
		@(negedge ref_clk);
		rst_n = 1'b0;
		repeat (12) @(negedge ref_clk);
		rst_n = 1'b1;
		curSel = bzd_pkg::PHS_RST[7:6];
	endtask
	// Threshold levels and channel parity pass straight through
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			wr(0, {i[1:0], 6'h00});
			chk(thresholdSelect === i[1:0], "threshold");
			parityReg = {1'b0, i[0], 6'h00};
			repeat (2) @(negedge ref_clk);
			chk(channelParitySel === i[0], "parity");
		end
		$display("regs done %0t", $time);
	endtask
	// One full motor step, begun right after a crossing or a reset
	task automatic step(input logic [7:0] crb, input logic [1:0] sel, input logic [7:0] cra,
		input logic [1:0] run, input logic [7:0] coef, input logic [7:0] dmv, input bit zOk);
		bit got;
		logic [1:0] expSel;
		logic [7:0] t;
		expSel = (sel == 2'h3) ? bzd_pkg::SEL_A : sel;
		@(negedge ref_clk);
		controlRegA = cra;
		pwmRun = run;
		corrCoef = coef;
		selPhase = expSel;
		zcRising = crb[bzd_pkg::CRB_POL_BIT];
		wr(0, crb);
		wr(1, {sel, 6'h00});
		wr(2, dmv);
		chk(inputPhaseSelect === curSel, "select moved early");
		wait_ev(0, 400, got);
		chk(got && !otherEv && waited > 200 && waited < 300, "commutation time");
		chk(stepTimer === 8'h10 && stepPhase === 2'h1 && inputPhaseSelect === sel,
			"commutation state");
		curSel = sel;
		wait_ev(1, 800, got);
		t = stepTimer;
		if (crb[4]) begin
			chk(got && !otherEv && t === dmv, "soft demag");
		end else begin
			// Same-edge relation waits for the later edge of the model
			chk(got && !otherEv && waited >= (parityReg[7] ? 700 : 300) &&
				waited < (parityReg[7] ? 1000 : 600), "hard demag");
		end
		if (crb[4:3] == 2'b01) begin
			repeat (2) @(posedge ref_clk);
			#1;
			chk(demagTimeReg === sc(t, coef) || demagTimeReg === sc(t - 8'h01, coef),
				"scaled capture");
		end
		if (!zOk) begin
			wait_ev(2, 400, got);
			chk(!got, "crossing from stopped source");
			@(negedge ref_clk);
			pwmRun = cra[3] ? 2'h2 : 2'h1;
		end
		wait_ev(2, 2000, got);
		chk(got && !otherEv && stepTimer === 8'h00 && stepPhase === 2'h0, "crossing");
		chk(zCapture === lastT || zCapture === lastT + 8'h01, "crossing capture");
		$display("step %h done %0t", crb, $time);
	endtask
	// Emulated value below the timer: no demag, no window, then reset mid-run
	task automatic t_late();
		bit got;
		@(negedge ref_clk);
		controlRegA = 8'h00;
		pwmRun = 2'h1;
		wr(0, 8'h10);
		wr(2, 8'h08);
		wait_ev(0, 400, got);
		chk(got, "commutation");
		wait_ev(1, 1500, got);
		chk(!got && !otherEv && stepPhase === 2'h1, "late demag taken");
		do_reset();
		#1;
		chk(demagTimeReg === bzd_pkg::DEMAG_RST && stepPhase === 2'h0 &&
			stepTimer === bzd_pkg::TMR_RST, "reset values");
		$display("late done %0t", $time);
	endtask
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		do_reset();
		t_regs();
		step(8'h28, 2'h1, 8'h00, 2'h1, 8'h10, 8'h00, 1'b1);
		step(8'h08, 2'h2, 8'h00, 2'h1, 8'hFF, 8'h00, 1'b1);
		step(8'h30, 2'h3, 8'h00, 2'h1, 8'h10, 8'h18, 1'b1);
		step(8'h28, 2'h0, 8'h00, 2'h2, 8'h10, 8'h00, 1'b0);
		step(8'h28, 2'h1, 8'h08, 2'h2, 8'h10, 8'h00, 1'b1);
		step(8'h28, 2'h2, 8'h08, 2'h1, 8'h10, 8'h00, 1'b0);
		step(8'h28, 2'h0, 8'h20, 2'h0, 8'h10, 8'h00, 1'b1);
		t_late();
		step(8'h28, 2'h1, 8'h00, 2'h1, 8'h10, 8'h00, 1'b1);
		// Same-edge relation of the demag edge to the crossing edge
		@(negedge ref_clk);
		parityReg = 8'h80;
		step(8'h28, 2'h2, 8'h00, 2'h1, 8'h10, 8'h00, 1'b1);
		wrap_up();
	end
endmodule
